/* verilog/modulo_interval_timer.sv */
`timescale 1ns/1ps
`default_nettype none
module modulo_interval_timer
  import interval_timer_pkg::*;
(
  input  wire logic       clk_sys_in,          // System clock
  input  wire logic       nrst_in,             // Power-on reset, low
  input  wire logic       watchdog_stack_reset_in, // Sync reset pulse
  input  wire logic       clock_stop_in,       // Sync clock-stop pulse
  input  wire logic       chip_enable_reset_in, // Sync CE reset pulse
  input  wire logic [5:0] addr_in,             // Register address
  input  wire logic       load_in,             // Read strobe
  input  wire logic       store_in,            // Write strobe
  input  wire logic [15:0] transfer_buffer_in, // Write data
  output logic      [15:0] transfer_buffer_out, // Read data
  output logic            irq_out              // Match pulse
);
  import interval_timer_pkg::*;
  logic [3:0] control_reg;
  logic [7:0] count_reg, count_next;
  logic [7:0] modulo_reg;
  logic [15:0] rdata_reg, rdata_next;
  logic       irq_reg;
  logic       tick;
  logic       hard_clr;
  logic       wr_ctl, wr_mod, do_clear, running, match;

  tick_prescaler u_pre (
    .clk_sys_in (clk_sys_in),
    .nrst_in    (nrst_in),
    .select_in  (control_reg[1:0]),
    .tick_out   (tick)
  );

  assign hard_clr = watchdog_stack_reset_in | clock_stop_in;
  assign wr_ctl   = store_in && addr_in == control_addr;
  assign wr_mod   = store_in && addr_in == modulo_addr;
  // Store to count address is ignored by hardware
  assign do_clear = wr_ctl && transfer_buffer_in[clear_bit_pos];
  assign running  = control_reg[run_bit_pos];
  assign match    = running && tick && (count_reg + 8'h01 == modulo_reg);

  always_comb begin
    count_next = count_reg;
    if (hard_clr) count_next = count_reset;
    else if (chip_enable_reset_in) count_next = {count_reg[7:1], 1'b0};
    else if (do_clear) count_next = count_reset;
    else if (match) count_next = count_reset;
    else if (running && tick) count_next = count_reg + 8'h01;
  end

  always_comb begin
    rdata_next = rdata_reg;
    if (load_in) begin
      case (addr_in)
        count_addr:   rdata_next = {8'h00, count_reg};
        modulo_addr:  rdata_next = {8'h00, modulo_reg};
        control_addr: rdata_next = {12'h000, control_reg[3], 1'b0, control_reg[1:0]};
        default:      rdata_next = 16'h0000;
      endcase
    end
  end

  always_ff @(posedge clk_sys_in or negedge nrst_in) begin
    if (!nrst_in) control_reg <= control_reset;
    else if (hard_clr) control_reg <= control_reset;
    else if (chip_enable_reset_in) control_reg <= control_reg;
    else if (wr_ctl) control_reg <= {transfer_buffer_in[3], 1'b0, transfer_buffer_in[1:0]};
  end

  always_ff @(posedge clk_sys_in or negedge nrst_in) begin
    if (!nrst_in) modulo_reg <= modulo_reset;
    else if (hard_clr) modulo_reg <= modulo_reset;
    else if (chip_enable_reset_in) modulo_reg <= modulo_reg;
    else if (wr_mod) modulo_reg <= transfer_buffer_in[7:0];
  end

  always_ff @(posedge clk_sys_in or negedge nrst_in) begin
    if (!nrst_in) begin
      count_reg <= count_reset;
      rdata_reg <= 16'h0000;
      irq_reg   <= 1'b0;
    end else begin
      count_reg <= count_next;
      rdata_reg <= rdata_next;
      irq_reg   <= match && !hard_clr;
    end
  end

  assign transfer_buffer_out = rdata_reg;
  assign irq_out             = irq_reg;
endmodule
`default_nettype wire

/* verilog/interval_timer_pkg.sv */
// What this block does
// - Control register zero on resets, kept on chip-enable
// - Clear bit always reads back zero
// - Count readable at its address, zero to ff
// - Count zero on resets; chip-enable clears bit0
// - Modulo register read/write; zero is forbidden
// - Modulo all ones on resets, kept otherwise
// - Periodic interrupt every modulo times tick period
// - Run starts unaligned to tick, up to +1
// - Stop unaligned to tick, up to -1
// - Software clear leaves prescaler unaligned
// - Clock select change applies immediately
// - Interrupt may coincide with other events
// - Select 00 100k, 01 10k, 10 2k, 11 1k
// - Bit 3 gates tick into counter
// - Writing one to bit 2 clears counter
// - Match requests interrupt unless watchdog or clock-stop coincides; clears counter unless chip-enable coincides
package interval_timer_pkg;
  localparam logic [5:0] modulo_addr        = 6'h1e;
  localparam logic [5:0] count_addr         = 6'h1f;
  localparam logic [5:0] control_addr       = 6'h29;
  localparam int         run_bit_pos        = 3;
  localparam int         clear_bit_pos      = 2;
  localparam logic [3:0] control_reset      = 4'h0;
  localparam logic [7:0] count_reset        = 8'h00;
  localparam logic [7:0] modulo_reset       = 8'hff;
  localparam longint     clk_hz             = 125000000;
  localparam longint     tick_100k_hz       = 100000;
  localparam longint     tick_10k_hz        = 10000;
  localparam longint     tick_2k_hz         = 2000;
  localparam longint     tick_1k_hz         = 1000;
  localparam int         pre_w              = 17;
  localparam logic [pre_w-1:0] div_100k = pre_w'(clk_hz / tick_100k_hz);
  localparam logic [pre_w-1:0] div_10k  = pre_w'(clk_hz / tick_10k_hz);
  localparam logic [pre_w-1:0] div_2k   = pre_w'(clk_hz / tick_2k_hz);
  localparam logic [pre_w-1:0] div_1k   = pre_w'(clk_hz / tick_1k_hz);
endpackage

/* verilog/tick_prescaler.sv */
`timescale 1ns/1ps
`default_nettype none
module tick_prescaler
  import interval_timer_pkg::*;
(
  input  wire logic       clk_sys_in,  // System clock
  input  wire logic       nrst_in,     // Async reset, low
  input  wire logic [1:0] select_in,   // Tick rate select
  output logic            tick_out     // One-cycle tick pulse
);
  logic [pre_w-1:0] cnt_reg;
  logic [pre_w-1:0] limit;
  logic             wrap;
  // Free running; never realigned by run, clear or select
  assign limit = (select_in == 2'b00) ? div_100k :
                 (select_in == 2'b01) ? div_10k :
                 (select_in == 2'b10) ? div_2k : div_1k;
  assign wrap     = (cnt_reg >= limit - pre_w'(1));
  assign tick_out = wrap;
  always_ff @(posedge clk_sys_in or negedge nrst_in) begin
    if (!nrst_in) cnt_reg <= '0;
    else cnt_reg <= wrap ? '0 : cnt_reg + pre_w'(1);
  end
endmodule
`default_nettype wire

/* test/timer_chk_assertions.sv */
`timescale 1ns/1ps
`default_nettype none
module timer_chk(
  input wire logic        clk_sys_in, nrst_in, watchdog_stack_reset_in, clock_stop_in, chip_enable_reset_in,
  input wire logic [5:0]  addr_in,
  input wire logic        load_in, store_in, irq_out,
  input wire logic [15:0] transfer_buffer_in, transfer_buffer_out);
  default clocking @(posedge clk_sys_in); endclocking
  default disable iff (!nrst_in);
  wire hard = watchdog_stack_reset_in || clock_stop_in;
  wire rdc  = load_in && !store_in && addr_in == 6'h29;
  wire rdm  = load_in && !store_in && addr_in == 6'h1e;
  AST_CLR_RD: assert property (rdc |=> !transfer_buffer_out[2]) else $error("clear bit read");
  AST_HI_ZERO: assert property (load_in |=> transfer_buffer_out[15:8] == 8'h00) else $error("upper");
  AST_CTL_RST: assert property (clock_stop_in ##1 rdc |=> transfer_buffer_out == 16'h0000) else $error("ctl");
  AST_MOD_RST: assert property (watchdog_stack_reset_in ##1 rdm |=> transfer_buffer_out[7:0] == 8'hff) else $error("mod");
  AST_CNT_RST: assert property (watchdog_stack_reset_in ##1 (load_in && addr_in == 6'h1f) |=>
    transfer_buffer_out[7:0] == 8'h00) else $error("cnt");
  AST_MOD_WR: assert property (store_in && addr_in == 6'h1e && !hard ##1 rdm && !hard |=>
    transfer_buffer_out[7:0] == $past(transfer_buffer_in[7:0], 2)) else $error("mod wr");
  AST_IRQ_ONE: assert property (irq_out |=> !irq_out) else $error("irq width");
  AST_STOP_QUIET: assert property (clock_stop_in |=> ##1 !irq_out[*8]) else $error("irq stop");
endmodule
bind modulo_interval_timer timer_chk timer_chk_inst(.*);
`default_nettype wire

/* test/irq_sink.sv */
`timescale 1ns/1ps
`default_nettype none
module irq_sink(
  input  wire logic clk_sys_in, // System clock
  input  wire logic nrst_in,    // Async reset, low
  input  wire logic irq_in,     // Interrupt request seen
  output var  int   seen_out    // Requests taken so far
);
  // Counts taken requests, as the core would
  always @(posedge clk_sys_in or negedge nrst_in) begin
    if (!nrst_in) seen_out <= 0;
    else if (irq_in) seen_out <= seen_out + 1;
  end
endmodule
`default_nettype wire

/* test/modulo_interval_timer_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module modulo_interval_timer_tb;
  import interval_timer_pkg::*;
  logic clk_sys_in, nrst_in, watchdog_stack_reset_in, clock_stop_in, chip_enable_reset_in, load_in, store_in, irq_out;
  logic [5:0]  addr_in;
  logic [15:0] transfer_buffer_in, transfer_buffer_out;
  logic [7:0]  m;
  int          n_errors, checks_done, seed, n, k, seen;
  modulo_interval_timer modulo_interval_timer_inst(.*);
  irq_sink irq_sink_inst(.clk_sys_in(clk_sys_in), .nrst_in(nrst_in), .irq_in(irq_out), .seen_out(seen));
  initial begin
    clk_sys_in = 0;
    forever #4 clk_sys_in = ~clk_sys_in;
  end
  // Clocks per interval from the selected tick rate
  function automatic int exp_cycles(input logic [1:0] sel, input int ticks);
    longint hz;
    hz = (sel == 2'b00) ? tick_100k_hz : (sel == 2'b01) ? tick_10k_hz : (sel == 2'b10) ? tick_2k_hz : tick_1k_hz;
    return int'(longint'(ticks) * (clk_hz / hz));
  endfunction
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wrap_up;
    $display("errors=%0d checks=%0d", n_errors, checks_done);
    if (n_errors == 0 && checks_done > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic acc(input logic s, input logic [5:0] a, input logic [15:0] d);
    @(posedge clk_sys_in) {store_in, load_in, addr_in, transfer_buffer_in} <= {s, !s, a, d};
    @(posedge clk_sys_in) {store_in, load_in} <= 2'b00;
    @(negedge clk_sys_in);
  endtask
  task automatic hit(input logic w, input logic c, input logic [5:0] a);
    @(posedge clk_sys_in) {watchdog_stack_reset_in, clock_stop_in, chip_enable_reset_in} <= {w, !w && !c, c};
    @(posedge clk_sys_in) {watchdog_stack_reset_in, clock_stop_in, chip_enable_reset_in, load_in, addr_in} <= {4'b0001, a};
    @(posedge clk_sys_in) load_in <= 1'b0;
    @(negedge clk_sys_in);
  endtask
  task automatic wirq;
    n = 0;
    do begin
      @(negedge clk_sys_in);
      n++;
    end while (irq_out !== 1'b1 && n < 30000);
    if (n >= 30000) begin
      n_errors++;
      wrap_up;
    end
  endtask
  initial begin
    seed = 32'hfa4c;
    {nrst_in, watchdog_stack_reset_in, clock_stop_in, chip_enable_reset_in, load_in, store_in} = 6'h00;
    addr_in = 6'h00;
    transfer_buffer_in = 16'h0000;
    repeat (2) @(posedge clk_sys_in);
    nrst_in <= 1'b1;
    acc(0, 6'h1e, 0); chk(transfer_buffer_out, 16'h00ff);
    acc(0, 6'h1f, 0); chk(transfer_buffer_out, 16'h0000);
    acc(0, 6'h29, 0); chk(transfer_buffer_out, 16'h0000);
    repeat (4) begin
      m = 8'($unsigned($random(seed)) % 255 + 1);
      acc(1, 6'h1e, {8'($random(seed)), m});
      acc(0, 6'h1e, 0); chk(transfer_buffer_out, {8'h00, m});
    end
    acc(1, 6'h29, 16'h000c); acc(0, 6'h29, 0); chk(transfer_buffer_out, 16'h0008);
    for (int s = 0; s < 2; s++) begin
      acc(1, 6'h1e, 2); acc(1, 6'h29, 16'(8 | s)); wirq; wirq;
      chk(16'(n), 16'(exp_cycles(2'(s), 2)));
    end
    acc(1, 6'h1e, 16'h00c3); acc(1, 6'h29, 16'h0008);
    repeat (1250 * 7 + 600) @(posedge clk_sys_in);
    acc(1, 6'h29, 0); acc(0, 6'h1f, 0); m = transfer_buffer_out[7:0];
    chk(16'(m >= 8'h07 && m <= 8'h08), 16'h0001);
    hit(0, 1, 6'h1f); chk(transfer_buffer_out, {8'h00, m & 8'hfe});
    // Count address is only ever read here
    // Chip-enable clearing of count bit0 is checked above
    acc(1, 6'h29, 16'h0004); acc(0, 6'h1f, 0); chk(transfer_buffer_out, 16'h0000);
    hit(1, 0, 6'h1e); chk(transfer_buffer_out, 16'h00ff);
    acc(1, 6'h1e, 1); acc(1, 6'h29, 16'h0008); hit(0, 0, 6'h29); chk(transfer_buffer_out, 0);
    k = seen;
    repeat (3000) @(posedge clk_sys_in);
    chk(16'(seen), 16'(k));
    wrap_up;
  end
endmodule
`default_nettype wire
